// *** spi_fram_slave.sv ***
// serial ferroelectric memory slave: parser, array, sleep and identity
`timescale 1ns/1ps
module spi_fram_slave
    import spi_fram_pkg::*;
#(
    parameter int         WAKE_CNT  = WAKE_CYCLES, // recovery in sys_clk
    parameter logic [7:0] CONT_CODE = 8'h5a,       // arbitrary value
    parameter logic [7:0] MFR_CODE  = 8'h3c,       // arbitrary value
    parameter logic [2:0] FAMILY    = 3'h4,        // arbitrary value
    parameter logic [4:0] DENSITY   = 5'h01,       // 128 kbit code
    parameter logic [2:0] SUB_TYPE  = 3'h2,        // arbitrary value
    parameter logic [2:0] REVISION  = 3'h1         // arbitrary value
) (
    // system clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // serial link pins
    input  wire logic       serial_clock,
    input  wire logic       chip_select_n,
    input  wire logic       serial_in,
    input  wire logic       pause_n,
    input  wire logic       write_protect_n,
    output logic            serial_out,
    output logic            serial_out_oe,
    // block protect straps
    input  wire logic       block_protect_hi,
    input  wire logic       block_protect_lo,
    // status
    output logic            write_latch_flag,
    output logic            asleep
);

    // ---------------- link domain (serial_clock) ----------------

    logic [7:0]  mem [MEM_DEPTH];          // the byte array
    link_state_t state_q;                  // frame parser state
    logic [2:0]  bit_q;                    // bit within current byte
    logic [7:0]  shift_q;                  // bits shifted in so far
    logic [7:0]  op_q;                     // opcode of this frame
    logic [13:0] addr_q;                   // current byte address
    logic [3:0]  id_idx_q;                 // identity byte index
    logic        so_q;                     // serial output bit
    logic        oe_q;                     // serial output enable
    logic [6:0]  out_sh_q;                 // remaining output bits
    logic        tgl_q;                    // toggles per finished opcode
    cmd_kind_t   kind_q;                   // meaning of last opcode
    link_ctl_t   ctl_s1;                   // control sync, first stage
    link_ctl_t   ctl_s2;                   // control sync, usable stage
    link_ctl_t   ctl_q;                    // control toward the link
    logic [7:0]  byte_in;                  // byte including current bit
    logic        byte_done;                // eighth bit this edge
    logic        link_go;                  // edge counts for the parser
    logic        out_phase;                // parser is sending data
    logic [7:0]  load_byte;                // next byte to send
    logic        wr_ok;                    // this data byte may be stored

    // current byte as seen at this rising edge
    assign byte_in   = {shift_q[6:0], serial_in};
    assign byte_done = (bit_q == BIT_LAST);
    // paused or asleep edges are dropped entirely
    assign link_go   = pause_n && ctl_s2.awake && !chip_select_n;
    assign out_phase = (state_q == ST_RDATA) || (state_q == ST_ID);
    // protection: pin at frame start and block code; the latch is checked at the opcode
    assign wr_ok     = ctl_s2.wp_ok && !is_protected(ctl_s2.bp, addr_q);

    // identity readout byte by index
    function automatic logic [7:0] id_byte(input logic [3:0] idx);
        if (idx < ID_CONT_N) begin
            id_byte = CONT_CODE;
        end else if (idx == ID_CONT_N) begin
            id_byte = MFR_CODE;
        end else if (idx == ID_PROD1) begin
            id_byte = {FAMILY, DENSITY};
        end else if (idx == ID_PROD2) begin
            id_byte = {SUB_TYPE, REVISION, 2'b00};
        end else begin
            id_byte = 8'h00;
        end
    endfunction

    // byte to present at the start of each output byte
    assign load_byte = (state_q == ST_ID) ? id_byte(id_idx_q)
                                          : mem[addr_q];

    // control levels from the system side, two stages
    always_ff @(posedge serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_s1 <= '0;
            ctl_s2 <= '0;
        end else begin
            ctl_s1 <= ctl_q;
            ctl_s2 <= ctl_s1;
        end
    end

    // frame parser; chip select high clears it without a clock
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            // deselect ends any transfer
            state_q  <= ST_CMD;
            bit_q    <= BIT_FIRST;
            shift_q  <= 8'h00;
            op_q     <= 8'h00;
            addr_q   <= ADDR_RESET;
            id_idx_q <= 4'h0;
        end else if (link_go) begin
            bit_q   <= bit_q + 3'h1;
            shift_q <= byte_in;
            if (byte_done) begin
                case (state_q)
                    // opcode byte
                    ST_CMD: begin
                        op_q <= byte_in;
                        case (byte_in)
                            // write only once the latch is set
                            OP_WRITE: begin
                                state_q <= ctl_s2.latch ? ST_ADDR_HI
                                                        : ST_IGNORE;
                            end
                            OP_READ, OP_FAST_READ: begin
                                state_q <= ST_ADDR_HI;
                            end
                            OP_ID: begin
                                state_q <= ST_ID;
                            end
                            default: begin
                                state_q <= ST_IGNORE;
                            end
                        endcase
                    end
                    // upper address bits, top two unused
                    ST_ADDR_HI: begin
                        addr_q[13:8] <= byte_in[5:0];
                        state_q      <= ST_ADDR_LO;
                    end
                    // lower address byte selects the next phase
                    ST_ADDR_LO: begin
                        addr_q[7:0] <= byte_in;
                        if (op_q == OP_WRITE) begin
                            state_q <= ST_WDATA;
                        end else if (op_q == OP_FAST_READ) begin
                            state_q <= ST_DUMMY;
                        end else begin
                            state_q <= ST_RDATA;
                        end
                    end
                    // latency byte, contents ignored
                    ST_DUMMY: begin
                        state_q <= ST_RDATA;
                    end
                    // data bytes: step address, wrapping at the top
                    ST_WDATA, ST_RDATA: begin
                        addr_q <= next_addr(addr_q);
                    end
                    // identity: walk through the readout
                    ST_ID: begin
                        if (id_idx_q != ID_END) begin
                            id_idx_q <= id_idx_q + 4'h1;
                        end
                    end
                    // rest of frame is ignored
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    // array write at the eighth bit; partial bytes never reach here
    always_ff @(posedge serial_clock) begin
        if (link_go && byte_done && (state_q == ST_WDATA) && wr_ok) begin
            mem[addr_q] <= byte_in;
        end
    end

    // opcode report to the system side, a toggle plus a stable kind
    always_ff @(posedge serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            tgl_q  <= 1'b0;
            kind_q <= KIND_NONE;
        end else if (link_go && byte_done && (state_q == ST_CMD)) begin
            tgl_q <= ~tgl_q;
            case (byte_in)
                OP_SET_LATCH: kind_q <= KIND_LATCH;
                OP_WRITE: begin
                    kind_q <= ctl_s2.latch ? KIND_WRITE : KIND_NONE;
                end
                OP_SLEEP:     kind_q <= KIND_SLEEP;
                default:      kind_q <= KIND_NONE;
            endcase
        end
    end

    // output shifter on falling edges; deselect releases the pin
    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            so_q     <= 1'b0;
            oe_q     <= 1'b0;
            out_sh_q <= 7'h00;
        end else if (pause_n) begin
            if (out_phase && ctl_s2.awake) begin
                oe_q <= 1'b1;
                if (bit_q == BIT_FIRST) begin
                    // new byte, most significant bit first
                    so_q     <= load_byte[7];
                    out_sh_q <= load_byte[6:0];
                end else begin
                    // next bit of the byte
                    so_q     <= out_sh_q[6];
                    out_sh_q <= {out_sh_q[5:0], 1'b0};
                end
            end else begin
                // asleep, waking or not sending
                oe_q <= 1'b0;
            end
        end
    end

    assign serial_out    = so_q;
    assign serial_out_oe = oe_q;

    // ---------------- system domain (sys_clk) ----------------

    logic        cs_s1;                    // chip select, first stage
    logic        cs_s2;                    // chip select, second stage
    logic        cs_s3;                    // delayed for edge detect
    logic        wp_s1;                    // write protect, first stage
    logic        wp_s2;                    // write protect, second stage
    logic [1:0]  bp_s1;                    // block protect, first stage
    logic [1:0]  bp_s2;                    // block protect, second stage
    logic        tg_s1;                    // opcode toggle, first stage
    logic        tg_s2;                    // opcode toggle, second stage
    logic        seen_q;                   // last toggle acted upon
    logic        latch_q;                  // write_latch_flag
    logic        asleep_q;                 // asleep or waking
    logic [WAKE_CNT_W-1:0] wake_cnt_q;     // recovery countdown
    logic        waking_q;                 // recovery running
    logic        wp_frame_q;               // pin value for this frame
    logic        cs_rise;                  // end of a frame
    logic        cs_fall;                  // start of a frame
    logic        new_cmd;                  // unseen opcode at frame end

    assign cs_rise = cs_s2 && !cs_s3;
    assign cs_fall = !cs_s2 && cs_s3;
    assign new_cmd = cs_rise && (tg_s2 != seen_q);

    // synchronisers for pins and the link toggle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
            bp_s1 <= 2'b00;
            bp_s2 <= 2'b00;
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
        end else begin
            cs_s1 <= chip_select_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            wp_s1 <= write_protect_n;
            wp_s2 <= wp_s1;
            bp_s1 <= {block_protect_hi, block_protect_lo};
            bp_s2 <= bp_s1;
            tg_s1 <= tgl_q;
            tg_s2 <= tg_s1;
        end
    end

    // write latch: set by its opcode, cleared when a write ends
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            seen_q  <= 1'b0;
            latch_q <= LATCH_RESET;
        end else if (new_cmd) begin
            seen_q <= tg_s2;
            if (kind_q == KIND_LATCH) begin
                latch_q <= 1'b1;
            end else if (kind_q == KIND_WRITE) begin
                latch_q <= 1'b0;
            end
        end
    end

    // sleep entry at frame end, wakeup timed from the next frame start
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            asleep_q   <= ASLEEP_RESET;
            waking_q   <= 1'b0;
            wake_cnt_q <= '0;
        end else if (waking_q) begin
            // recovery running, link still held off
            if (wake_cnt_q == '0) begin
                waking_q <= 1'b0;
                asleep_q <= 1'b0;
            end else begin
                wake_cnt_q <= wake_cnt_q - WAKE_CNT_W'(1);
            end
        end else if (asleep_q && cs_fall) begin
            // only chip select is watched while asleep
            waking_q   <= 1'b1;
            wake_cnt_q <= WAKE_CNT_W'(WAKE_CNT - 1);
        end else if (new_cmd && (kind_q == KIND_SLEEP)) begin
            asleep_q <= 1'b1;
        end
    end

    // protect pin taken once per frame, at its start
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wp_frame_q <= 1'b1;
        end else if (cs_fall) begin
            wp_frame_q <= wp_s2;
        end
    end

    // control bundle sent to the link side
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctl_q <= '0;
        end else begin
            ctl_q.awake <= !asleep_q;
            ctl_q.latch <= latch_q;
            ctl_q.wp_ok <= wp_frame_q;
            ctl_q.bp    <= bp_s2;
        end
    end

    assign write_latch_flag = latch_q;
    assign asleep           = asleep_q;

endmodule

// *** spi_fram_pkg.sv ***
// constants, types and helpers for the serial ferroelectric memory slave
package spi_fram_pkg;

    // array geometry
    localparam int          ADDR_W     = 14;           // byte address width
    localparam int          MEM_DEPTH  = 16384;        // bytes in the array
    localparam logic [13:0] ADDR_TOP   = 14'h3fff;     // last location
    localparam logic [13:0] ADDR_BASE  = 14'h0000;     // wrap target
    localparam logic [13:0] ADDR_RESET = 14'h0000;     // address after reset

    // opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;       // set_write_latch
    localparam logic [7:0] OP_WRITE     = 8'h02;       // memory write
    localparam logic [7:0] OP_READ      = 8'h03;       // memory read
    localparam logic [7:0] OP_FAST_READ = 8'h0b;       // fast_read_cmd
    localparam logic [7:0] OP_SLEEP     = 8'hb9;       // sleep entry
    localparam logic [7:0] OP_ID        = 8'h9f;       // identity_query_cmd

    // block protect range bases
    localparam logic [13:0] PROT_QUARTER = 14'h3000;   // code 01
    localparam logic [13:0] PROT_HALF    = 14'h2000;   // code 10

    // bit and byte counting
    localparam logic [2:0] BIT_FIRST = 3'h0;           // first bit of byte
    localparam logic [2:0] BIT_LAST  = 3'h7;           // eighth bit of byte
    localparam logic [3:0] ID_CONT_N = 4'h6;           // continuation bytes
    localparam logic [3:0] ID_PROD1  = 4'h7;           // first product byte
    localparam logic [3:0] ID_PROD2  = 4'h8;           // second product byte
    localparam logic [3:0] ID_END    = 4'h9;           // past the readout

    // reset values
    localparam logic       LATCH_RESET  = 1'b0;        // writes disabled
    localparam logic       ASLEEP_RESET = 1'b0;        // starts awake

    // wakeup recovery
    localparam int WAKE_RECOVERY_US = 400;             // longest recovery
    localparam int SYS_CLK_MHZ      = 250;             // sys_clk rate
    localparam int WAKE_CYCLES      = WAKE_RECOVERY_US * SYS_CLK_MHZ;
    localparam int WAKE_CNT_W       = 17;              // timer width

    // frame parser states
    typedef enum logic [2:0] {
        ST_CMD     = 3'b000,
        ST_ADDR_HI = 3'b001,
        ST_ADDR_LO = 3'b010,
        ST_DUMMY   = 3'b011,
        ST_WDATA   = 3'b100,
        ST_RDATA   = 3'b101,
        ST_ID      = 3'b110,
        ST_IGNORE  = 3'b111
    } link_state_t;

    // what a finished opcode asks of the system side
    typedef enum logic [1:0] {
        KIND_NONE  = 2'b00,
        KIND_LATCH = 2'b01,
        KIND_WRITE = 2'b10,
        KIND_SLEEP = 2'b11
    } cmd_kind_t;

    // quasi-static control handed to the link side
    typedef struct packed {
        logic       awake;     // normal operation allowed
        logic       latch;     // write_latch_flag
        logic       wp_ok;     // write protect pin inactive at frame start
        logic [1:0] bp;        // block_protect_hi, block_protect_lo
    } link_ctl_t;

    // true when the block protect code covers this address
    function automatic logic is_protected(input logic [1:0] bp,
                                          input logic [13:0] addr);
        case (bp)
            2'b01:   is_protected = (addr >= PROT_QUARTER);
            2'b10:   is_protected = (addr >= PROT_HALF);
            2'b11:   is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    // next sequential address with wrap at the top
    function automatic logic [13:0] next_addr(input logic [13:0] addr);
        if (addr == ADDR_TOP) begin
            next_addr = ADDR_BASE;
        end else begin
            next_addr = addr + 14'h0001;
        end
    endfunction

endpackage

// *** spi_fram_props.sv ***
// checker for the serial memory slave's pins
`timescale 1ns/1ps
module spi_fram_props
    import spi_fram_pkg::*;
(
    // system side
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic write_latch_flag,
    input wire logic asleep,
    // serial pins
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic pause_n,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic [5:0] bits_q;  // edges taken in this frame
    logic [7:0] op_q;    // opcode of this frame

    // count taken edges, capture the opcode
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            bits_q <= 6'h00;
            op_q   <= 8'h00;
        end else if (pause_n && bits_q != 6'h3f) begin
            bits_q <= bits_q + 6'h01;
            op_q   <= (bits_q < 6'h08) ? {op_q[6:0], serial_in} : op_q;
        end
    end
    // awake frame of opcode o has taken n edges
    sequence s_at(o, n);
        op_q == o && bits_q == n && !asleep;
    endsequence

    a_oe_released: assert property (@(posedge sys_clk)
        disable iff (!rst_n) chip_select_n |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_sleep_quiet: assert property (@(posedge sys_clk)
        disable iff (!rst_n) asleep |-> !serial_out_oe)
        else $error("output driven while asleep");
    a_sleep_entry: assert property (@(posedge sys_clk)
        disable iff (!rst_n) $rose(asleep) |-> chip_select_n)
        else $error("sleep entered inside a frame");
    a_latch_clear: assert property (@(posedge sys_clk)
        disable iff (!rst_n) $fell(write_latch_flag) |-> chip_select_n)
        else $error("latch cleared inside a frame");
    a_read_latency: assert property (@(posedge serial_clock)
        disable iff (chip_select_n) s_at(OP_READ, 24) |-> serial_out_oe)
        else $error("read data not started");
    a_fast_latency: assert property (@(posedge serial_clock)
        disable iff (chip_select_n) s_at(OP_FAST_READ, 24)
        |-> !serial_out_oe ##8 serial_out_oe) else $error("fast read");
    a_id_latency: assert property (@(posedge serial_clock)
        disable iff (chip_select_n) s_at(OP_ID, 8) |-> serial_out_oe)
        else $error("identity not started");
    a_pause_freeze: assert property (@(negedge serial_clock)
        disable iff (chip_select_n) !pause_n
        |=> $stable(serial_out) && $stable(serial_out_oe))
        else $error("output moved while paused");
endmodule

bind spi_fram_slave spi_fram_props u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .write_latch_flag(write_latch_flag),
    .asleep(asleep), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .pause_n(pause_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));

// *** spi_host_model.sv ***
// serial bus master model driving the memory's pins
`timescale 1ns/1ps
module spi_host_model (
    // master drive
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_in,
    output logic pause_n,
    // device answer
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    // idle: clock low, deselected, not paused
    initial begin
        {serial_clock, chip_select_n, serial_in, pause_n} = 4'h1;
        // a real rising select edge clears the link flops at start
        #1 chip_select_n = 1'b1;
    end
    // select off the system clock phase
    task automatic start();
        #41.7 chip_select_n = 1'b0;
        #40;
    endtask
    // deselect after every frame; line stops holding the last bit
    task automatic stop();
        #40 chip_select_n = 1'b1;
        serial_in = ~serial_in;
        #80;
    endtask
    // shift n bits msb first, answer taken before the rising edge
    task automatic xbyte(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            serial_in = tx[7 - i];
            #39 rx = {rx[6:0], serial_out_oe ? serial_out : 1'bz};
            #1 serial_clock = 1'b1;
            #40 serial_clock = 1'b0;
        end
    endtask
    // pause with clock low, idle clocks, resume with clock low
    task automatic hold(input int n);
        #20 pause_n = 1'b0;
        repeat (n) begin
            #20 serial_clock = 1'b1;
            #20 serial_clock = 1'b0;
        end
        #20 pause_n = 1'b1;
        #20;
    endtask
endmodule

// *** tb.sv ***
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
module tb;
    import spi_fram_pkg::*;
    localparam int WK = 1000;    // shortened wake recovery
    logic       sys_clk = 1'b0;
    logic       rst_n;           // falls at time zero, a true edge
    logic       wp_n    = 1'b1;  // write protect inactive
    logic [1:0] bp      = 2'h0;  // block protect code
    logic       sck, cs_n, si, hold_n, so, so_oe, wlf, slp;
    logic [7:0] r, q0, q1;
    int         n_errors = 0, compares = 0, cyc = 0;

    spi_fram_slave #(.WAKE_CNT(WK)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .serial_clock(sck), .chip_select_n(cs_n), .serial_in(si),
        .pause_n(hold_n), .write_protect_n(wp_n), .serial_out(so),
        .serial_out_oe(so_oe), .block_protect_hi(bp[1]),
        .block_protect_lo(bp[0]), .write_latch_flag(wlf), .asleep(slp));
    spi_host_model m (.serial_clock(sck), .chip_select_n(cs_n),
        .serial_in(si), .pause_n(hold_n), .serial_out(so),
        .serial_out_oe(so_oe));

    initial forever #2 sys_clk = ~sys_clk;
    // cut a hang short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // opcode and two address bytes
    task automatic hdr(input logic [7:0] op, input logic [13:0] a);
        m.start();
        m.xbyte(op, 8, r);
        m.xbyte({2'h0, a[13:8]}, 8, r);
        m.xbyte(a[7:0], 8, r);
    endtask
    task automatic cmd(input logic [7:0] op);
        m.start();
        m.xbyte(op, 8, r);
        m.stop();
    endtask
    // optional latch, then bytes d and ~d
    task automatic wr(input logic [13:0] a, input logic [7:0] d,
                      input logic en);
        if (en) cmd(OP_SET_LATCH);
        chk({7'h00, wlf}, {7'h00, en});
        hdr(OP_WRITE, a);
        m.xbyte(d, 8, r);
        m.xbyte(~d, 8, r);
        m.stop();
        chk({7'h00, wlf}, 8'h00);
    endtask
    task automatic rd(input logic [7:0] op, input logic [13:0] a);
        hdr(op, a);
        if (op == OP_FAST_READ) m.xbyte(8'hc3, 8, r);
        m.xbyte(8'h00, 8, q0);
        m.xbyte(8'hff, 8, q1);
        m.stop();
    endtask
    task automatic sys(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // stored, refused and partial writes
    task automatic t_write();
        wr(14'h0010, 8'h11, 1'b1);
        wr(14'h0010, 8'h99, 1'b0);
        cmd(OP_SET_LATCH);
        hdr(OP_WRITE, 14'h0011);
        m.xbyte(8'h00, 7, r);
        m.stop();
        rd(OP_READ, 14'h0010);
        chk(q0, 8'h11);
        chk(q1, 8'hee);
    endtask
    // write over the top, fast read across the wrap
    task automatic t_wrap();
        wr(14'h3fff, 8'ha5, 1'b1);
        rd(OP_FAST_READ, 14'h3fff);
        chk(q0, 8'ha5);
        chk(q1, 8'h5a);
    endtask
    // each protect code, then the pin, must spare 3fff
    task automatic t_protect();
        for (int c = 1; c < 5; c++) begin
            @(posedge sys_clk);
            bp <= (c < 4) ? c[1:0] : 2'h0;
            wp_n <= (c < 4);
            wr(14'h3fff, 8'h00, 1'b1);
        end
        @(posedge sys_clk);
        wp_n <= 1'b1;
        rd(OP_READ, 14'h3fff);
        chk(q0, 8'ha5);
    endtask
    task automatic t_pause();
        hdr(OP_READ, 14'h0010);
        m.xbyte(8'h00, 4, q0);
        m.hold(3);
        m.xbyte(8'h00, 4, q1);
        m.stop();
        chk({q0[3:0], q1[3:0]}, 8'h11);
    endtask
    task automatic t_id();
        logic [7:0] e;
        m.start();
        m.xbyte(OP_ID, 8, r);
        for (int i = 0; i < 9; i++) begin
            e = i < 6 ? 8'h5a : i == 6 ? 8'h3c : i == 7 ? 8'h81 : 8'h44;
            m.xbyte(8'h00, 8, r);
            chk(r, e);
        end
        m.stop();
    endtask
    // sleep, silent throwaway read, recovery, normal read
    task automatic t_sleep();
        cmd(OP_SLEEP);
        chk({7'h00, slp}, 8'h01);
        rd(OP_READ, 14'h0010);
        chk(q0, 8'hzz);
        sys(WK + 40);
        chk({7'h00, slp}, 8'h00);
        cmd(8'h00);  // polling frame primes the link control sync
        rd(OP_READ, 14'h0010);
        chk(q0, 8'h11);
    endtask
    initial begin
        rst_n <= 1'b0;  // edge seen by the asynchronously reset link flops
        sys(12);
        rst_n <= 1'b1;
        sys(4);
        cmd(8'h00);  // settles the link side after reset
        t_write();
        t_wrap();
        t_protect();
        t_pause();
        t_id();
        t_sleep();
        end_of_test();
    end
endmodule
